// *** src/adsr_pkg.sv ***
// Shared constants and types for the converter status and mode register pair
package adsr_pkg;

   // ==========================================================
   // Register selection and widths
   localparam int REG_W = 8;
   localparam logic [1:0] SEL_STATUS = 2'h0;
   localparam logic [1:0] SEL_MODE = 2'h1;
   localparam logic [3:0] BITS_PER_REG = 4'h8;
   localparam logic [3:0] LAST_BIT = 4'h1;

   // ==========================================================
   // Status field layout
   localparam int SR_RDY = 7;
   localparam int SR_ERR = 6;
   localparam int SR_ZHI = 5;
   localparam int SR_ONE = 3;
   localparam int SR_WL = 2;
   localparam int SR_CHH = 1;
   localparam logic [2:0] SR_FIXED = 3'h1;

   // ==========================================================
   // Mode field layout and reset value
   localparam int MR_MDH = 7;
   localparam int MR_MDL = 6;
   localparam int MR_UB = 2;
   localparam logic [7:0] MODE_RST = 8'h02;

   // ==========================================================
   // Serial interface reset: consecutive ones on the data input
   localparam logic [5:0] SRST_LAST = 6'h1f;

   typedef enum logic [1:0] {
      ADSR_CONT = 2'b00,
      ADSR_SINGLE = 2'b01,
      ADSR_STBY = 2'b10
   } adsr_mode_t;

   // Converter-side events, all one-cycle pulses on clk
   typedef struct packed {
      logic result_write;
      logic result_clamped;
      logic pre_update;
      logic data_read;
   } adsr_evt_t;

   // Controls towards the modulator and filter
   typedef struct packed {
      logic [1:0] operating_mode_select;
      logic unipolar;
      logic powered_down;
      logic filter_reset;
   } adsr_conv_t;

   // Command from the communications-register decoder, on sclk
   typedef struct packed {
      logic valid;
      logic read;
      logic [1:0] register_select;
   } adsr_cmd_t;

endpackage

// *** src/adsr_regs.sv ***
// Status and mode register pair with serial shifter on the link clock
//
// Summary of operation
// - Status is eight bits, read only
// - Status shifts out most significant bit first
// - New result written clears the ready flag
// - Data read or pre-update sets ready
// - Entering power-down sets ready
// - Error flag follows clamp, updated with ready
// - Conversion-starting write clears error flag
// - Status bits five, four zero; three one
// - Bit two is fixed word length id
// - Bits one, zero report converted channel
// - Mode register read/write, select one, reset 0x02
// - Mode write resets filter, sets ready
// - Mode shifts MSB first; mode, coding fields
// - Coding bit picks unipolar or offset binary
// - Mode field picks continuous, single, standby
`timescale 1ns/1ns
module adsr_regs
   import adsr_pkg::*;
#(
   parameter logic WORD_LEN_ID = 1'b0
) (
   // System clock domain
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // Converter side
   input wire adsr_evt_t evt,
   input wire logic [1:0] channel_code,
   output adsr_conv_t conv,
   output logic [7:0] status,
   output logic [7:0] mode,
   // Serial link, clocked by sclk
   input wire logic sclk,
   input wire logic din,
   input wire adsr_cmd_t cmd,
   output logic dout,
   output logic dout_active
);

   // ==========================================================
   // Core state on clk
   typedef struct packed {
      logic ready;
      logic err;
      logic [1:0] chan;
      logic [7:0] mode;
      logic single_done;
      logic pd_prev;
      logic filter_reset;
      logic [2:0] wsync;
      logic [2:0] rsync;
      logic [1:0] async;
      logic [15:0] pub_word;
      logic pub_tog;
   } adsr_core_t;

   // Link state on sclk
   typedef struct packed {
      logic [1:0] rst_sync;
      logic [1:0] psync;
      logic ack_tog;
      logic [15:0] snap;
      logic [7:0] shreg;
      logic [3:0] cnt;
      logic rd;
      logic [7:0] wword;
      logic wtog;
      logic [5:0] ones;
      logic stog;
   } adsr_link_t;

   adsr_core_t c_reg, c_next;
   adsr_link_t l_reg, l_next;
   logic mode_wr, srst, pd_now, start_conv;
   adsr_mode_t md, md_new;
   logic [7:0] status_now;

   // ==========================================================
   // Core next state
   assign md = adsr_mode_t'(c_reg.mode[MR_MDH:MR_MDL]);
   assign md_new = adsr_mode_t'(l_reg.wword[MR_MDH:MR_MDL]);
   assign mode_wr = c_reg.wsync[2] ^ c_reg.wsync[1];
   assign srst = c_reg.rsync[2] ^ c_reg.rsync[1];
   // Standby or a finished single conversion leaves the modulator off
   assign pd_now = (md != ADSR_CONT && md != ADSR_SINGLE) ||
      (md == ADSR_SINGLE && c_reg.single_done);
   assign start_conv = mode_wr && (md_new == ADSR_CONT || md_new == ADSR_SINGLE);
   assign status_now = {c_reg.ready, c_reg.err, SR_FIXED, WORD_LEN_ID, c_reg.chan};

   always_comb begin
      c_next = c_reg;
      c_next.filter_reset = 1'b0;
      // First stage of each synchroniser feeds only the second
      c_next.wsync = {c_reg.wsync[1:0], l_reg.wtog};
      c_next.rsync = {c_reg.rsync[1:0], l_reg.stog};
      c_next.async = {c_reg.async[0], l_reg.ack_tog};
      c_next.chan = channel_code;
      c_next.pd_prev = pd_now;
      if (evt.result_write) begin
         c_next.ready = 1'b0;
         if (md == ADSR_SINGLE) begin
            c_next.single_done = 1'b1;
         end
      end
      if (start_conv) begin
         c_next.err = 1'b0;
      end
      if (evt.result_write) begin
         c_next.err = evt.result_clamped;
      end
      if (mode_wr) begin
         // Word is held by the link side until the next write
         c_next.mode = l_reg.wword;
         c_next.filter_reset = 1'b1;
         c_next.single_done = 1'b0;
      end
      // Set wins over the clear of the same cycle
      if (evt.data_read || evt.pre_update) begin
         c_next.ready = 1'b1;
      end
      if (pd_now && !c_reg.pd_prev) begin
         c_next.ready = 1'b1;
      end
      if (mode_wr) begin
         c_next.ready = 1'b1;
      end
      if (srst) begin
         c_next.mode = MODE_RST;
         c_next.ready = 1'b1;
         c_next.err = 1'b0;
         c_next.single_done = 1'b0;
         c_next.filter_reset = 1'b1;
      end
      // Publish a fresh snapshot only once the link acknowledged the last
      if (c_reg.async[1] == c_reg.pub_tog) begin
         c_next.pub_word = {status_now, c_reg.mode};
         c_next.pub_tog = ~c_reg.pub_tog;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         c_reg <= '0;
         c_reg.mode <= MODE_RST;
         c_reg.ready <= 1'b1;
      end else if (ce) begin
         c_reg <= c_next;
      end
   end

   assign status = status_now;
   assign mode = c_reg.mode;
   // One assignment drives the whole struct, so no field has a second driver
   assign conv = {c_reg.mode[MR_MDH:MR_MDL], c_reg.mode[MR_UB],
      pd_now, c_reg.filter_reset};

   // ==========================================================
   // Link next state on sclk
   always_comb begin
      l_next = l_reg;
      l_next.rst_sync = {l_reg.rst_sync[0], rstn};
      l_next.psync = {l_reg.psync[0], c_reg.pub_tog};
      if (l_reg.psync[1] != l_reg.ack_tog) begin
         l_next.snap = c_reg.pub_word;
         l_next.ack_tog = l_reg.psync[1];
      end
      l_next.ones = din ? l_reg.ones + 6'h01 : 6'h00;
      if (l_reg.cnt != 4'h0) begin
         l_next.cnt = l_reg.cnt - 4'h1;
         l_next.shreg = {l_reg.shreg[6:0], din};
         if (!l_reg.rd && l_reg.cnt == LAST_BIT) begin
            l_next.wword = {l_reg.shreg[6:0], din};
            l_next.wtog = ~l_reg.wtog;
         end
      end else if (cmd.valid) begin
         // Writes to status fall through unanswered: it is read only
         if (cmd.read && cmd.register_select == SEL_STATUS) begin
            l_next.shreg = l_reg.snap[15:8];
            l_next.rd = 1'b1;
            l_next.cnt = BITS_PER_REG;
         end else if (cmd.register_select == SEL_MODE) begin
            l_next.shreg = cmd.read ? l_reg.snap[7:0] : 8'h00;
            l_next.rd = cmd.read;
            l_next.cnt = BITS_PER_REG;
         end
      end
      if (din && l_reg.ones == SRST_LAST) begin
         l_next.stog = ~l_reg.stog;
         l_next.ones = 6'h00;
         l_next.cnt = 4'h0;
         l_next.rd = 1'b0;
      end
   end

   always_ff @(posedge sclk) begin
      if (!l_reg.rst_sync[1]) begin
         l_reg <= '0;
         l_reg.rst_sync <= l_next.rst_sync;
      end else begin
         l_reg <= l_next;
      end
   end

   assign dout_active = l_reg.rd && l_reg.cnt != 4'h0;
   assign dout = dout_active ? l_reg.shreg[7] : 1'b1;

   // ==========================================================
   // Checks on the core domain
   fixed_bits_a: assert property (@(posedge clk) disable iff (!rstn)
      status[SR_ZHI:SR_ONE] == SR_FIXED && status[SR_WL] == WORD_LEN_ID)
      else $error("status constant bits wrong");

   ready_clear_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && evt.result_write && !evt.data_read && !evt.pre_update && !mode_wr && !srst
      && !(pd_now && !c_reg.pd_prev) |=> !status[SR_RDY])
      else $error("ready not cleared by new result");

   ready_set_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && (evt.data_read || evt.pre_update) |=> status[SR_RDY])
      else $error("ready not set by read or pre-update");

   pd_ready_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && pd_now && !c_reg.pd_prev |=> status[SR_RDY])
      else $error("ready not set on power-down");

   err_track_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && evt.result_write && !srst |=> status[SR_ERR] == $past(evt.result_clamped))
      else $error("error flag does not follow clamp");

   err_clear_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && start_conv && !evt.result_write |=> !status[SR_ERR])
      else $error("error flag not cleared by start");

   chan_track_a: assert property (@(posedge clk) disable iff (!rstn)
      ce ##1 ce |-> status[SR_CHH:0] == $past(channel_code))
      else $error("channel code not reported");

   mode_reset_a: assert property (@(posedge clk) disable iff (!rstn)
      $rose(rstn) |-> mode == MODE_RST && status[SR_RDY])
      else $error("mode not at reset value");

   logic filter_reset_q;
   assign filter_reset_q = conv.filter_reset;
   sequence mode_taken_s;
      filter_reset_q ##0 status[SR_RDY];
   endsequence
   mode_write_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && mode_wr && !srst |=> mode_taken_s ##0 mode == $past(l_reg.wword))
      else $error("mode write not applied");

   single_done_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && evt.result_write && md == ADSR_SINGLE && !mode_wr && !srst
      |=> conv.powered_down)
      else $error("single conversion did not power down");

   serial_reset_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && srst |=> mode == MODE_RST && status[SR_RDY] && !status[SR_ERR])
      else $error("serial reset did not restore defaults");

   fr_cause_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && !mode_wr && !srst |=> !conv.filter_reset)
      else $error("filter reset without a mode write");

   // ==========================================================
   // Checks on the link domain
   logic lrst_n;
   assign lrst_n = l_reg.rst_sync[1];
   sequence read_start_s;
      l_reg.cnt == 4'h0 && cmd.valid && cmd.read && cmd.register_select == SEL_STATUS
      && !(din && l_reg.ones == SRST_LAST);
   endsequence
   msb_first_a: assert property (@(posedge sclk) disable iff (!lrst_n)
      read_start_s |=> dout == $past(l_reg.snap[15]) && dout_active
      ##1 (dout_active -> dout == $past(l_reg.snap[14], 2)))
      else $error("status not shifted msb first");

   // A low data bit at the command edge keeps a serial reset out of the frame
   read_len_a: assert property (@(posedge sclk) disable iff (!lrst_n)
      read_start_s ##0 !din |=> dout_active [*8] ##1 !dout_active)
      else $error("status read not eight bits long");

   sequence status_write_s;
      l_reg.cnt == 4'h0 && cmd.valid && !cmd.read && cmd.register_select == SEL_STATUS;
   endsequence
   status_ro_a: assert property (@(posedge sclk) disable iff (!lrst_n)
      status_write_s |=> !dout_active ##8 $stable(l_reg.wtog))
      else $error("write to status was accepted");

   sequence mode_write_start_s;
      l_reg.cnt == 4'h0 && cmd.valid && !cmd.read && cmd.register_select == SEL_MODE
      && !din;
   endsequence
   // A frame of eight data bits hands over exactly one word
   write_toggle_a: assert property (@(posedge sclk) disable iff (!lrst_n)
      mode_write_start_s |=> ##7 $stable(l_reg.wtog) ##1 $changed(l_reg.wtog))
      else $error("mode write frame length wrong");

endmodule // adsr_regs

// *** tb/adsr_host.sv ***
// Host model driving the serial register link
`timescale 1ns/1ns
module adsr_host
   import adsr_pkg::*;
(
   // Link towards the register pair
   output logic sclk,
   output logic din,
   output adsr_cmd_t cmd,
   input wire logic dout,
   input wire logic dout_active
);
   // ==========
   // Link clock starts low and rests low between ticks
   initial begin
      sclk = 1'b0;
      din = 1'b0;
      cmd = '0;
   end

   // ==========
   // One link clock period; signals change on the falling edge only
   task automatic tick(input logic d, input adsr_cmd_t c);
      din = d;
      cmd = c;
      #3 sclk = 1'b1;
      #3 sclk = 1'b0;
   endtask

   task automatic idle(input int n);
      for (int i = 0; i < n; i++) tick(1'b0, '0);
   endtask

   // Idle clocks first, so the read snapshot has time to refresh
   task automatic xfer(input logic rd, input logic [1:0] sel, input logic [7:0] wd,
                       output logic [7:0] rdat, output logic ok);
      idle(16);
      tick(1'b0, {1'b1, rd, sel});
      ok = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         rdat[i] = dout;
         if (dout_active !== rd) ok = 1'b0;
         tick(rd ? 1'b0 : wd[i], '0);
      end
      if (dout_active !== 1'b0 || dout !== 1'b1) ok = 1'b0;
      idle(4);
   endtask

   task automatic serial_reset();
      for (int i = 0; i < 32; i++) tick(1'b1, '0);
      idle(4);
   endtask
endmodule // adsr_host

// *** tb/adsr_regs_test.sv ***
// Self-checking bench for the status and mode register pair
`timescale 1ns/1ns
module adsr_regs_test;
   import adsr_pkg::*;
   // ==========
   // Signals
   logic clk, rstn, ce, sclk, din, dout, dout_active, ok, fr_seen;
   adsr_evt_t evt;
   adsr_conv_t conv;
   adsr_cmd_t cmd;
   logic [1:0] channel_code;
   logic [7:0] status, mode, rd;
   int error_cnt = 0;
   int check_count = 0;
   int cycles = 0;
   // Reset status: ready set, fixed bits, default word length id, channel zero
   localparam logic [7:0] ST_RST = {2'h2, SR_FIXED, 3'h0};

   adsr_regs adsr_regs_i (.clk(clk), .rstn(rstn), .ce(ce), .evt(evt),
      .channel_code(channel_code), .conv(conv), .status(status), .mode(mode),
      .sclk(sclk), .din(din), .cmd(cmd), .dout(dout), .dout_active(dout_active));
   adsr_host adsr_host_i (.sclk(sclk), .din(din), .cmd(cmd), .dout(dout),
      .dout_active(dout_active));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Filter reset is a single pulse, so it is latched here
   always @(posedge clk) begin
      cycles++;
      if (conv.filter_reset === 1'b1) fr_seen <= 1'b1;
      if (cycles == 5000) begin
         error_cnt++;
         results();
      end
   end

   // ==========
   // Shared tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [1:0] sel, input logic [7:0] exp);
      adsr_host_i.xfer(1'b1, sel, 8'h00, rd, ok);
      chk(rd, exp);
      chk({7'h0, ok}, 8'h01);
   endtask

   task automatic wr_mode(input logic [7:0] v);
      adsr_host_i.xfer(1'b0, SEL_MODE, v, rd, ok);
      repeat (10) @(negedge clk);
   endtask

   task automatic pulse(input adsr_evt_t e);
      @(negedge clk) evt = e;
      @(negedge clk) evt = '0;
      repeat (2) @(negedge clk);
   endtask

   // ==========
   // Scenarios
   task automatic t_reset();
      chk(mode, 8'h02);
      chk(status, ST_RST);
      rd_chk(SEL_STATUS, ST_RST);
      rd_chk(SEL_MODE, 8'h02);
   endtask

   task automatic t_events();
      @(negedge clk) channel_code = 2'h3;
      pulse(4'hc);
      chk(status, 8'h4b);
      rd_chk(SEL_STATUS, 8'h4b);
      pulse(4'h1);
      chk(status, 8'hcb);
      pulse(4'h8);
      chk(status, 8'h0b);
      pulse(4'h2);
      chk(status, 8'h8b);
   endtask

   task automatic t_mode();
      pulse(4'hc);
      fr_seen = 1'b0;
      wr_mode(8'h06);
      chk({7'h0, fr_seen}, 8'h01);
      chk(status, 8'h8b);
      chk({7'h0, conv.unipolar}, 8'h01);
      rd_chk(SEL_MODE, 8'h06);
   endtask

   task automatic t_modes();
      wr_mode(8'h42);
      chk({6'h0, conv.operating_mode_select}, 8'h01);
      chk({7'h0, conv.unipolar}, 8'h00);
      chk({7'h0, conv.powered_down}, 8'h00);
      pulse(4'hc);
      chk({7'h0, conv.powered_down}, 8'h01);
      chk(status, 8'hcb);
      // Standby does not start a conversion, so the error flag survives
      wr_mode(8'h82);
      chk(status, 8'hcb);
      chk({7'h0, conv.powered_down}, 8'h01);
      wr_mode(8'hc2);
      chk({6'h0, conv.operating_mode_select}, 8'h03);
      chk({7'h0, conv.powered_down}, 8'h01);
   endtask

   task automatic t_refuse();
      adsr_host_i.xfer(1'b0, SEL_STATUS, 8'h00, rd, ok);
      repeat (10) @(negedge clk);
      chk(status, 8'hcb);
      chk(mode, 8'hc2);
   endtask

   task automatic t_srst();
      adsr_host_i.serial_reset();
      repeat (10) @(negedge clk);
      chk(mode, 8'h02);
      chk(status, 8'h8b);
   endtask

   task automatic results();
      if (error_cnt == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      evt = '0;
      channel_code = 2'h0;
      fr_seen = 1'b0;
      // Link side needs its own clock edges to see the reset
      fork
         begin
            #1;
            adsr_host_i.idle(4);
         end
         repeat (8) @(negedge clk);
      join
      rstn = 1'b1;
      repeat (6) @(negedge clk);
      t_reset();
      t_events();
      t_mode();
      t_modes();
      t_refuse();
      t_srst();
      results();
   end
endmodule // adsr_regs_test
